// ### logic/tmv_pkg.sv
// tmv_pkg: register map, field positions, reset values and bus carriers
// for the eight-bit compare timer.
// assumes a single 32-bit AHB-Lite slave port with word-aligned registers.
package tmv_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] TMV_OFF_COUNT   = 8'h00;
    localparam logic [7:0] TMV_OFF_CMP_A   = 8'h04;
    localparam logic [7:0] TMV_OFF_CMP_B   = 8'h08;
    localparam logic [7:0] TMV_OFF_CTRL0   = 8'h0c;
    localparam logic [7:0] TMV_OFF_STATUS  = 8'h10;
    localparam logic [7:0] TMV_OFF_CTRL1   = 8'h14;

    // ------------------------------------------------------------
    // reset values and counter maximum
    // ------------------------------------------------------------
    localparam logic [7:0] TMV_RST_COUNT   = 8'h00;
    localparam logic [7:0] TMV_RST_CMP     = 8'hff;
    localparam logic [7:0] TMV_RST_CTRL0   = 8'h00;
    localparam logic [7:0] TMV_CNT_MAX     = 8'hff;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    // flags in timer_status_control, also the enables in count_control_zero
    localparam int TMV_BIT_FLAG_B    = 7;
    localparam int TMV_BIT_FLAG_A    = 6;
    localparam int TMV_BIT_FLAG_WRAP = 5;
    // status bit 4 and control-one bits 7..5 always read as one
    localparam logic [7:0] TMV_STATUS_RD_ONE = 8'h10;
    localparam logic [7:0] TMV_CTRL1_RD_ONE  = 8'he0;
    localparam int TMV_BIT_TRIG_EN   = 2;
    localparam int TMV_BIT_DIV_PAIR  = 0;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] TMV_CLR_NONE  = 2'h0;
    localparam logic [1:0] TMV_CLR_MA    = 2'h1;
    localparam logic [1:0] TMV_CLR_MB    = 2'h2;
    localparam logic [1:0] TMV_CLR_PIN   = 2'h3;
    localparam logic [1:0] TMV_OUT_KEEP  = 2'h0;
    localparam logic [1:0] TMV_OUT_LOW   = 2'h1;
    localparam logic [1:0] TMV_OUT_HIGH  = 2'h2;
    localparam logic [1:0] TMV_OUT_TOG   = 2'h3;
    localparam logic [1:0] TMV_HTRANS_NONSEQ = 2'h2;

    // control register zero layout
    typedef struct packed {
        logic [2:0] irq_enable;   // match_b, match_a, overflow
        logic [1:0] clear_select; // clear_select_hi, clear_select_lo
        logic [2:0] clock_select; // clock_select_2..0
    } tmv_ctrl0_t;

    // AHB-Lite request side as seen by the slave
    typedef struct packed {
        logic        hsel;
        logic [7:0]  haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } tmv_ahb_req_t;

endpackage : tmv_pkg

// ### logic/tmv_timer.sv
// tmv_timer: eight-bit up counter with two compare channels, clear and
// trigger control, one waveform pin and an interrupt request line.
// assumes one system clock, AHB-Lite single word transfers, and pins that
// are asynchronous to the system clock.
`timescale 1ns/1ps

// Notes on behaviour
// R1: counter is eight bits and steps by one on each selected count edge
// R2: software may read and write the counter at any time
// R3: counter resets to zero
// R4: counter overflow sets the overflow flag
// R5: compare registers A and B are eight-bit read/write, reset to all ones
// R6: each compare register is compared continuously; equality sets its match flag
// R7: channel B behaves exactly like channel A
// R8: compare is suppressed while that compare register is being written
// R9: a set match flag with its enable set requests an interrupt
// R10: enables at bits 7, 6, 5 of control zero, read/write, reset zero
// R11: clear field: none, match A, match B, or external clear pin rising edge
// R12: after a pin clear, trigger enable decides whether counting halts
// R13: internal sources count falling edges of clock over 4 to 128
// R14: external pin counts rising, falling or both edges; 000 and 100 stop
// R15: an edge on the trigger pin can start counting, edge selectable
// R16: with count stop selected the counter halts when cleared until restarted
// R17: waveform pin driven independently by both match events
// R18: flags clear by writing 0 after reading 1; only hardware sets them
// R19: per channel select: keep, drive 0, drive 1, toggle; pin 0 after reset
// R20: trigger edge field: off, rising, falling, both
// R21: trigger enable allows trigger start and halt on match clear
// R22: counter wraps to zero; interrupt is OR of flag AND enable
module tmv_timer
    import tmv_pkg::*;
(
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rstn_i,
    // AHB-Lite slave
    input  wire tmv_ahb_req_t ahb_i,
    output logic              hreadyout_o,
    output logic              hresp_o,
    output logic [31:0]       hrdata_o,
    // timer pins
    input  wire logic         ext_count_clock_pin_i,
    input  wire logic         ext_clear_pin_i,
    input  wire logic         start_trigger_pin_i,
    output logic              wave_out_pin_o,
    output logic              irq_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0]  count_value_r;
    logic [7:0]  count_value_nxt;
    logic [7:0]  cmp_r [2];          // index 0 = channel A, 1 = channel B
    tmv_ctrl0_t  ctrl0_r;
    logic [1:0]  trig_edge_r;        // trigger_edge_hi, trigger_edge_lo
    logic        trig_en_r;
    logic        div_pair_r;
    logic [1:0]  out_sel_r [2];      // per channel output select
    logic [2:0]  flag_r;             // b, a, overflow in status bit order
    logic [2:0]  armed_r;            // flag was read as one
    logic [2:0]  flag_set;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic        rd_take;
    logic        wr_take;
    logic [7:0]  rd_mux;
    logic [7:0]  wdat;
    logic [6:0]  presc_r;
    logic [2:0]  sync1_r;
    logic [2:0]  sync2_r;
    logic [2:0]  sync3_r;
    logic [2:0]  pin_lvl_r;
    logic [2:0]  pin_rise;
    logic [2:0]  pin_fall;
    logic        run_r;
    logic        count_tick;
    logic        int_tick;
    logic        ext_tick;
    logic [1:0]  eq_prev_r;
    logic [1:0]  match;
    logic        clr_match;
    logic        clr_pin;
    logic        trig_edge;
    logic        can_count;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    // a valid address phase is taken whenever the bus is ready
    assign rd_take = ahb_i.hsel & ahb_i.hready & ahb_i.htrans[1] & ~ahb_i.hwrite;
    assign wr_take = ahb_i.hsel & ahb_i.hready & ahb_i.htrans[1] & ahb_i.hwrite;
    assign wdat    = ahb_i.hwdata[7:0];

    // the slave never stalls and never errors
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
        else
        begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    // write address is held for the data phase, data lands at its end
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end
        else
        begin
            if (ahb_i.hready)
            begin
                wr_pend_r <= wr_take;
                wr_addr_r <= {ahb_i.haddr[7:2], 2'b00};
            end
        end
    end

    // read data is sampled at the address phase edge so hrdata is a flop;
    // a read right behind a write to the same word sees the old value
    always_comb
    begin
        rd_mux = 8'h00;
        case ({ahb_i.haddr[7:2], 2'b00})
            TMV_OFF_COUNT:  rd_mux = count_value_r;                     // R2
            TMV_OFF_CMP_A:  rd_mux = cmp_r[0];
            TMV_OFF_CMP_B:  rd_mux = cmp_r[1];
            TMV_OFF_CTRL0:  rd_mux = ctrl0_r;
            TMV_OFF_STATUS: rd_mux = {flag_r, 1'b0, out_sel_r[1], out_sel_r[0]}
                                     | TMV_STATUS_RD_ONE;
            TMV_OFF_CTRL1:  rd_mux = {3'b000, trig_edge_r, trig_en_r, 1'b0, div_pair_r}
                                     | TMV_CTRL1_RD_ONE;
            default:        rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            hrdata_o <= 32'h0000_0000;
        else if (rd_take)
            hrdata_o <= {24'h00_0000, rd_mux};
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl0_r     <= TMV_RST_CTRL0;                               // R10
            trig_edge_r <= 2'b00;
            trig_en_r   <= 1'b0;
            div_pair_r  <= 1'b0;
            out_sel_r   <= '{2'b00, 2'b00};
        end
        else if (wr_pend_r)
        begin
            case (wr_addr_r)
                TMV_OFF_CTRL0:  ctrl0_r <= wdat;                        // R10
                TMV_OFF_CTRL1:
                begin
                    trig_edge_r <= wdat[4:3];
                    trig_en_r   <= wdat[TMV_BIT_TRIG_EN];
                    div_pair_r  <= wdat[TMV_BIT_DIV_PAIR];
                end
                TMV_OFF_STATUS:
                begin
                    out_sel_r[1] <= wdat[3:2];
                    out_sel_r[0] <= wdat[1:0];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    // three stages; a new level is accepted only once stages two and three
    // agree, which filters a single-cycle glitch at the cost of latency
    genvar gp;
    generate
        for (gp = 0; gp < 3; gp++)
        begin : g_pin
            always_ff @(posedge clk_sys_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    sync1_r[gp]   <= 1'b0;
                    sync2_r[gp]   <= 1'b0;
                    sync3_r[gp]   <= 1'b0;
                    pin_lvl_r[gp] <= 1'b0;
                end
                else
                begin
                    sync1_r[gp] <= (gp == 0) ? ext_count_clock_pin_i :
                                   (gp == 1) ? ext_clear_pin_i : start_trigger_pin_i;
                    sync2_r[gp] <= sync1_r[gp];
                    sync3_r[gp] <= sync2_r[gp];
                    if (sync2_r[gp] == sync3_r[gp])
                        pin_lvl_r[gp] <= sync3_r[gp];
                end
            end
            assign pin_rise[gp] = (sync2_r[gp] == sync3_r[gp]) & sync3_r[gp] & ~pin_lvl_r[gp];
            assign pin_fall[gp] = (sync2_r[gp] == sync3_r[gp]) & ~sync3_r[gp] & pin_lvl_r[gp];
        end
    endgenerate

    // ------------------------------------------------------------
    // count source selection
    // ------------------------------------------------------------
    // free-running prescaler; a falling edge of clock/2^(k+1) is bit k
    // going from one to zero, i.e. bits k..0 all one before the step
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            presc_r <= 7'h00;
        else
            presc_r <= presc_r + 7'h01;
    end

    always_comb
    begin
        int_tick = 1'b0;
        case ({ctrl0_r.clock_select[1:0], div_pair_r})                  // R13
            3'b010:  int_tick = &presc_r[1:0];
            3'b011:  int_tick = &presc_r[2:0];
            3'b100:  int_tick = &presc_r[3:0];
            3'b101:  int_tick = &presc_r[4:0];
            3'b110:  int_tick = &presc_r[5:0];
            3'b111:  int_tick = &presc_r[6:0];
            default: int_tick = 1'b0;
        endcase
    end

    always_comb
    begin
        ext_tick = 1'b0;
        case (ctrl0_r.clock_select[1:0])                                // R14
            2'b01:   ext_tick = pin_rise[0];
            2'b10:   ext_tick = pin_fall[0];
            2'b11:   ext_tick = pin_rise[0] | pin_fall[0];
            default: ext_tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // start, stop and clear control
    // ------------------------------------------------------------
    always_comb
    begin
        trig_edge = 1'b0;
        case (trig_edge_r)                                              // R20
            2'b01:   trig_edge = pin_rise[2];
            2'b10:   trig_edge = pin_fall[2];
            2'b11:   trig_edge = pin_rise[2] | pin_fall[2];
            default: trig_edge = 1'b0;
        endcase
    end

    // clear events, in the same cycle as the match they depend on
    assign clr_match = (ctrl0_r.clear_select == TMV_CLR_MA & match[0]) |
                       (ctrl0_r.clear_select == TMV_CLR_MB & match[1]); // R11
    assign clr_pin   = (ctrl0_r.clear_select == TMV_CLR_PIN) & pin_rise[1]; // R11

    // with trigger enable off the counter always runs; with it on, a
    // trigger edge starts it and any clear stops it again
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            run_r <= 1'b0;
        else if (!trig_en_r)
            run_r <= 1'b0;
        else if (clr_match | clr_pin)
            run_r <= 1'b0;                                              // R12 R16 R21
        else if (trig_edge)
            run_r <= 1'b1;                                              // R15 R21
    end

    assign can_count  = ~trig_en_r | run_r;
    assign count_tick = can_count & (ctrl0_r.clock_select[2] ? ext_tick : int_tick);

    // ------------------------------------------------------------
    // main counter
    // ------------------------------------------------------------
    // priority: software write, then clear, then count
    always_comb
    begin
        count_value_nxt = count_value_r;
        if (wr_pend_r && wr_addr_r == TMV_OFF_COUNT)
            count_value_nxt = wdat;                                     // R2
        else if (clr_match | clr_pin)
            count_value_nxt = 8'h00;                                    // R11
        else if (count_tick)
            count_value_nxt = count_value_r + 8'h01;                    // R1 R22
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            count_value_r <= TMV_RST_COUNT;                             // R3
        else
            count_value_r <= count_value_nxt;
    end

    // ------------------------------------------------------------
    // compare channels
    // ------------------------------------------------------------
    // a match is the first cycle of equality; the compare is masked while
    // a write to that channel is in its data phase so a half-updated
    // value cannot produce a false match
    genvar gc;
    generate
        for (gc = 0; gc < 2; gc++)
        begin : g_cmp                                                   // R7
            logic eq;
            logic wr_here;
            assign wr_here = wr_pend_r &
                             (wr_addr_r == ((gc == 0) ? TMV_OFF_CMP_A : TMV_OFF_CMP_B));
            assign eq      = (count_value_r == cmp_r[gc]) & ~wr_here;   // R6 R8
            assign match[gc] = eq & ~eq_prev_r[gc];

            always_ff @(posedge clk_sys_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    cmp_r[gc]     <= TMV_RST_CMP;                       // R5
                    eq_prev_r[gc] <= 1'b0;
                end
                else
                begin
                    eq_prev_r[gc] <= eq;
                    if (wr_here)
                        cmp_r[gc] <= wdat;                              // R5
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    assign flag_set[2] = match[1];                                      // R6
    assign flag_set[1] = match[0];                                      // R6
    assign flag_set[0] = count_tick & (count_value_r == TMV_CNT_MAX)
                         & ~(wr_pend_r && wr_addr_r == TMV_OFF_COUNT)
                         & ~(clr_match | clr_pin);                      // R4

    // a flag clears only on a zero write after it was read as one; the
    // hardware set wins over a clear in the same cycle
    genvar gf;
    generate
        for (gf = 0; gf < 3; gf++)
        begin : g_flag
            logic wr_clr;
            assign wr_clr = wr_pend_r & (wr_addr_r == TMV_OFF_STATUS)
                            & ~wdat[TMV_BIT_FLAG_WRAP + gf] & armed_r[gf];

            always_ff @(posedge clk_sys_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    flag_r[gf]  <= 1'b0;
                    armed_r[gf] <= 1'b0;
                end
                else
                begin
                    if (flag_set[gf])
                        flag_r[gf] <= 1'b1;                             // R18
                    else if (wr_clr)
                        flag_r[gf] <= 1'b0;                             // R18
                    if (wr_clr)
                        armed_r[gf] <= 1'b0;
                    else if (rd_take && {ahb_i.haddr[7:2], 2'b00} == TMV_OFF_STATUS
                             && flag_r[gf])
                        armed_r[gf] <= 1'b1;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // waveform pin and interrupt request
    // ------------------------------------------------------------
    // channel B is applied after A, so B acts on A's result when both match together
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            wave_out_pin_o <= 1'b0;                                     // R19
        else
        begin
            if (match[1])
            begin
                case (out_sel_r[1])                                     // R17 R19
                    TMV_OUT_LOW:  wave_out_pin_o <= 1'b0;
                    TMV_OUT_HIGH: wave_out_pin_o <= 1'b1;
                    TMV_OUT_TOG:  wave_out_pin_o <= ~(match[0] ? (out_sel_r[0] == TMV_OUT_LOW ? 1'b0 :
                                                     out_sel_r[0] == TMV_OUT_HIGH ? 1'b1 :
                                                     out_sel_r[0] == TMV_OUT_TOG ? ~wave_out_pin_o :
                                                     wave_out_pin_o) : wave_out_pin_o);
                    default:      wave_out_pin_o <= match[0] ? (out_sel_r[0] == TMV_OUT_LOW ? 1'b0 :
                                                     out_sel_r[0] == TMV_OUT_HIGH ? 1'b1 :
                                                     out_sel_r[0] == TMV_OUT_TOG ? ~wave_out_pin_o :
                                                     wave_out_pin_o) : wave_out_pin_o;
                endcase
            end
            else if (match[0])
            begin
                case (out_sel_r[0])                                     // R17 R19
                    TMV_OUT_LOW:  wave_out_pin_o <= 1'b0;
                    TMV_OUT_HIGH: wave_out_pin_o <= 1'b1;
                    TMV_OUT_TOG:  wave_out_pin_o <= ~wave_out_pin_o;
                    default:      wave_out_pin_o <= wave_out_pin_o;
                endcase
            end
        end
    end

    // registered so the pin is glitch free
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(flag_r & ctrl0_r.irq_enable);                    // R9 R22
    end

endmodule : tmv_timer

// ### sim/tmv_timer_properties.sv
// checker for the ports of tmv_timer
// assumes a zero wait state slave and one system clock
`timescale 1ns/1ps
module tmv_chk
    import tmv_pkg::*;
(
    // watched ports
    input wire logic         clk_sys_i,
    input wire logic         rstn_i,
    input wire tmv_ahb_req_t ahb_i,
    input wire logic         hreadyout_o,
    input wire logic         hresp_o,
    input wire logic [31:0]  hrdata_o,
    input wire logic         wave_out_pin_o,
    input wire logic         irq_o
);
    logic       tk, rd, wr_q;
    logic [7:0] a_q;
    logic [7:0] e_r;
    logic [7:0] m_r [4];
    assign tk = ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1];
    assign rd = tk && !ahb_i.hwrite;
    // mirror of the plain registers, old value on a read
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_q <= 1'b0;
            a_q  <= 8'h00;
            e_r  <= 8'h00;
            m_r  <= '{8'h00, TMV_RST_CMP, TMV_RST_CMP, TMV_RST_CTRL0};
        end
        else
        begin
            wr_q <= tk && ahb_i.hwrite;
            a_q  <= ahb_i.haddr;
            e_r  <= m_r[ahb_i.haddr[3:2]];
            if (wr_q && a_q inside {8'h04, 8'h08, 8'h0c})
                m_r[a_q[3:2]] <= ahb_i.hwdata[7:0];
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    sequence s_rd(logic [7:0] a);
        rd && ahb_i.haddr == a;
    endsequence
    a_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus stall");
    a_rdata_hold: assert property (!rd |=> $stable(hrdata_o))
        else $error("rdata moved");
    a_status_one: assert property (s_rd(TMV_OFF_STATUS) |=> hrdata_o[4])
        else $error("status bit 4");
    a_ctrl1_fixed: assert property (s_rd(TMV_OFF_CTRL1) |=> &hrdata_o[7:5] && !hrdata_o[1])
        else $error("ctrl1 fixed bits");
    a_unmapped_zero: assert property (rd && ahb_i.haddr > 8'h14 |=> hrdata_o == 32'h0)
        else $error("unmapped read");
    a_regs_back: assert property (rd && ahb_i.haddr inside {8'h04, 8'h08, 8'h0c} |=> hrdata_o == {24'h0, e_r})
        else $error("read back");
    a_irq_masked: assert property (m_r[3][7:5] == 3'h0 |=> !irq_o)
        else $error("irq masked");
    a_reset_quiet: assert property ($rose(rstn_i) |-> !wave_out_pin_o && !irq_o)
        else $error("pins after reset");
endmodule : tmv_chk
bind tmv_timer tmv_chk u_chk (.*);

// ### sim/tmv_pin_model.sv
// pin model: external count clock, clear and start trigger pins
// assumes the timer filters its pins over a few system clocks
`timescale 1ns/1ps
module tmv_pins
(
    // clock
    input  wire logic clk_sys_i,
    // pins
    output logic      ext_clk_o = 1'b0,
    output logic      ext_clr_o = 1'b0,
    output logic      trig_o    = 1'b0
);
    // 8 clocks a level outlast the pin filter
    task automatic pulse(input int pin, input int n);
        for (int i = 0; i < 2 * n; i++)
        begin
            repeat (8) @(posedge clk_sys_i);
            case (pin)
                0: ext_clk_o <= !ext_clk_o;
                1: ext_clr_o <= !ext_clr_o;
                default: trig_o <= !trig_o;
            endcase
        end
        repeat (8) @(posedge clk_sys_i);
    endtask : pulse
endmodule : tmv_pins

// ### sim/tb_top.sv
// tb_top: bus master and checks for tmv_timer
// assumes hready is fed back from hreadyout
`timescale 1ns/1ps
module tb_top
    import tmv_pkg::*;
;
    logic         clk_sys_i = 1'b0;
    logic         rstn_i    = 1'b0;
    tmv_ahb_req_t req       = '0;
    logic         rdy, hresp, wave, irq, pc, pr, pt;
    logic [31:0]  hrdata, rd;
    logic [7:0]   v;
    int           err_count = 0;
    int           comparisons = 0;
    // rows: write flag, offset, write data, expected read
    logic [27:0]  rows [14] = '{28'h0000000, 28'h00400ff, 28'h00800ff, 28'h00c0000,
        28'h0100010, 28'h01400e0, 28'h1043c3c, 28'h108c3c3, 28'h10ce0e0, 28'h1141dfd,
        28'h11400e0, 28'h110e010, 28'h1008080, 28'h118ff00};
    tmv_timer uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ahb_i({req.hsel, req.haddr,
        req.htrans, req.hwrite, req.hsize, rdy, req.hwdata}), .hreadyout_o(rdy),
        .hresp_o(hresp), .hrdata_o(hrdata), .ext_count_clock_pin_i(pc),
        .ext_clear_pin_i(pr), .start_trigger_pin_i(pt), .wave_out_pin_o(wave), .irq_o(irq));
    tmv_pins pins (.clk_sys_i(clk_sys_i), .ext_clk_o(pc), .ext_clr_o(pr), .trig_o(pt));
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d = 8'h00);
        req.haddr  <= a;
        req.hwrite <= w;
        req.htrans <= TMV_HTRANS_NONSEQ;
        req.hsize  <= 3'h2;
        do @(posedge clk_sys_i); while (rdy !== 1'b1);
        req.htrans <= 2'h0;
        req.hwdata <= {24'h0, d};
        do @(posedge clk_sys_i); while (rdy !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wait_wave(input logic l);
        repeat (200) if (wave !== l) @(posedge clk_sys_i);
        chk("wave", 32'(l), 32'(wave));
    endtask : wait_wave
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up
    initial
    begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        #200us;
        err_count++;
        wrap_up;
    end
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        rstn_i   <= 1'b1;
        req.hsel <= 1'b1;
        @(posedge clk_sys_i);
        foreach (rows[i])
        begin
            if (rows[i][24])
                bus(1, rows[i][23:16], rows[i][15:8]);
            bus(0, rows[i][23:16]);
            chk("reg", {24'h0, rows[i][7:0]}, rd);
        end
        $display("regs done");
        // internal divisors: window of 258 clocks, one tick of slack
        for (int k = 0; k < 6; k++)
        begin
            bus(1, TMV_OFF_COUNT, 8'h00);
            bus(1, TMV_OFF_CTRL1, 8'(k % 2));
            bus(1, TMV_OFF_CTRL0, 8'(k / 2 + 1));
            repeat (256) @(posedge clk_sys_i);
            bus(1, TMV_OFF_CTRL0, 8'h00);
            bus(0, TMV_OFF_COUNT);
            v = 8'(256 >> (k + 2));
            chk("rate", 1, 32'(rd[7:0] >= v - 1 && rd[7:0] <= v + 1));
        end
        for (int k = 4; k < 8; k++)
        begin
            bus(1, TMV_OFF_COUNT, 8'h00);
            bus(1, TMV_OFF_CTRL0, 8'(k));
            pins.pulse(0, 4);
            bus(0, TMV_OFF_COUNT);
            chk("ext", (k == 4) ? 0 : (k == 7) ? 8 : 4, rd);
        end
        $display("sources done");
        bus(0, TMV_OFF_STATUS);
        bus(1, TMV_OFF_STATUS, 8'h00);
        bus(1, TMV_OFF_COUNT, 8'hfc);
        bus(1, TMV_OFF_CTRL0, 8'h21);
        repeat (100) if (irq !== 1'b1) @(posedge clk_sys_i);
        chk("irq", 1, 32'(irq));
        bus(1, TMV_OFF_CTRL0, 8'h20);
        bus(0, TMV_OFF_STATUS);
        chk("ovf", 32'h30, rd);
        bus(1, TMV_OFF_STATUS, 8'h00);
        bus(0, TMV_OFF_STATUS);
        chk("ovf clr", 32'h10, rd);
        chk("irq clr", 0, 32'(irq));
        $display("overflow done");
        bus(1, TMV_OFF_CMP_A, 8'h08);
        bus(1, TMV_OFF_CMP_B, 8'h02);
        bus(1, TMV_OFF_STATUS, 8'h09);
        bus(1, TMV_OFF_CTRL0, 8'h09);
        wait_wave(1);
        wait_wave(0);
        bus(1, TMV_OFF_STATUS, 8'h0c);
        bus(1, TMV_OFF_CTRL0, 8'h11);
        wait_wave(1);
        wait_wave(0);
        bus(1, TMV_OFF_CTRL0, 8'h00);
        bus(0, TMV_OFF_COUNT);
        chk("clr b", 1, 32'(rd <= 2));
        $display("compare done");
        bus(1, TMV_OFF_CTRL0, 8'h19);
        for (int t = 0; t < 4; t++)
        begin
            bus(1, TMV_OFF_CTRL1, 8'(t * 8 + 4));
            bus(1, TMV_OFF_COUNT, 8'h40);
            pins.pulse(2, 1);
            bus(0, TMV_OFF_COUNT);
            chk("trig", 32'(t > 0), 32'(rd > 8'h40));
            pins.pulse(1, 1);
            bus(0, TMV_OFF_COUNT);
            chk("pin clr", 0, rd);
        end
        $display("trigger done");
        rstn_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(posedge clk_sys_i);
        bus(0, TMV_OFF_CMP_A);
        chk("rst cmp", 32'hff, rd);
        chk("rst wave", 0, 32'(wave));
        $display("reset done");
        wrap_up;
    end
endmodule : tb_top
